// File: pkg/fepseq_defines.vh
// Constants for the flash erase and program sequencer core.
// Included by bare name from core and bench files.
`ifndef FEPSEQ_DEFINES_VH
`define FEPSEQ_DEFINES_VH

// Register indices
`define FEP_A_CTRL 4'h0
`define FEP_A_STAT 4'h1
`define FEP_A_IADDR 4'h2
`define FEP_A_IDATA 4'h3
`define FEP_A_WER0 4'h4
`define FEP_A_WER1 4'h5
`define FEP_A_WER2 4'h6
`define FEP_A_FWS 4'h7
`define FEP_A_PWS 4'h8
`define FEP_A_MODE 4'h9

// Control bits
`define FEP_C_PE 0
`define FEP_C_PER 1
`define FEP_C_MER 2

// Status bits, the two fail flags are write-one-to-clear
`define FEP_S_BUSY 0
`define FEP_S_FULL 1
`define FEP_S_ERASE_FAIL_FLAG 2
`define FEP_S_PROGRAM_FAIL_FLAG 3

// Array operation codes, one-hot
`define FEP_OP_PROG 3'h1
`define FEP_OP_PERASE 3'h2
`define FEP_OP_MERASE 3'h4

// Main block address map
`define FEP_BLK2_TAG 11'h068
`define FEP_PG01_MASK 24'h00_03FF
`define FEP_PG2_MASK 24'h00_01FF

// Info words read at reset
`define FEP_FW_ADDR 24'h00_007E
`define FEP_PW_ADDR 24'h00_00FE
`define FEP_NO_BOOT 4'hF
`define FEP_WER_RST 16'h0000

// Start-up modes, one-hot
`define FEP_M_ISP 4'h1
`define FEP_M_INT 4'h2
`define FEP_M_EXT 4'h4
`define FEP_M_DBG 4'h8

`endif

// File: core/fepseq_core.v
// Flash erase/program sequencer with reset-time protection word decode.
// Assumes a flash array that takes one operation per start pulse and
// answers with done; reads answer with rvalid.
//
// Summary of operation
// - Pages: 1024 bytes program blocks, 512 data
// - Page erase needs section enable, spares boot
// - Page erase starts on write when idle
// - Module erase needs all enables of its block; block 0 also needs no boot
// - Module erase starts on any block write
// - Info erase also erases main; boot blocks it for info block 0
// - Info erase via address then data write
// - Program needs write guard off, section enable
// - Only aligned whole-word program writes
// - Word write starts pipelined program, sets busy
// - Info program indirect; block 0 refused
// - Status shows program and erase fail flags
// - Reset copies function word into shadow
// - Reset copies protection word into shadow
// - Inverted boot size gives 2K units
// - Loader start without boot area holds reset
// - Empty flag is majority voted
// - Straps with blank select loader start
// - Loader flag and blank choose start point
// - Debug start ignores empty, starts at zero
// - Read guard blocks debug and external reads
// - Write guard blocks writes and debug reads
// - Full flag clear means next word accepted, except while an erase is busy
`timescale 1ns/1ps
`include "fepseq_defines.vh"

module fepseq_core #(
    parameter AW = 24,
    parameter DW = 16
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Register port
    input wire [3:0] i_reg_addr,
    input wire [DW-1:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output wire [DW-1:0] o_reg_rdata,
    // Processor writes into main block space
    input wire i_mem_wr,
    input wire [AW-1:0] i_mem_addr,
    input wire [1:0] i_mem_be,
    input wire [DW-1:0] i_mem_wdata,
    // Strap pins
    input wire i_strap_pin_0,
    input wire i_strap_pin_1,
    // Flash array
    output wire o_arr_start,
    output wire [2:0] o_arr_op,
    output wire o_arr_info,
    output wire [AW-1:0] o_arr_addr,
    output wire [DW-1:0] o_arr_wdata,
    output wire o_arr_rd,
    input wire i_arr_done,
    input wire i_arr_rvalid,
    input wire [DW-1:0] i_arr_rdata,
    // Start-up decode, guards and busy flag
    output wire o_boot_done,
    output wire [3:0] o_start_mode,
    output wire [AW-1:0] o_start_addr,
    output wire o_hold_reset,
    output wire o_prog_write_allow,
    output wire o_ext_read_allow,
    output wire o_dbg_read_allow,
    output wire o_flash_busy_flag
);

    localparam S_LOAD = 5'b00001;
    localparam S_LWAIT = 5'b00010;
    localparam S_DEC = 5'b00100;
    localparam S_IDLE = 5'b01000;
    localparam S_OP = 5'b10000;

    reg [4:0] state_q;
    reg ld_idx_q;
    reg [DW-1:0] function_word_shadow_q;
    reg [DW-1:0] protection_word_shadow_q;
    reg [2:0] ctrl_q;
    reg erase_fail_flag_q;
    reg program_fail_flag_q;
    reg [7:0] info_addr_reg_q;
    reg [DW-1:0] info_data_reg_q;
    reg [DW-1:0] wer0_q;
    reg [DW-1:0] wer1_q;
    reg [DW-1:0] wer2_q;
    reg [2:0] op_q;
    reg pend_q;
    reg [AW-1:0] pend_addr_q;
    reg [DW-1:0] pend_data_q;
    reg pend_info_q;
    reg start_q;
    reg info_q;
    reg [AW-1:0] addr_q;
    reg [DW-1:0] wdata_q;
    reg rd_q;
    reg [DW-1:0] rdata_q;
    reg done_q;
    reg [3:0] mode_q;
    reg [AW-1:0] saddr_q;
    reg hold_q;
    reg s0_m_q;
    reg s0_q;
    reg s1_m_q;
    reg s1_q;

    function maj3;
        input [2:0] v;
        begin
            maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction

    // Protection word fields
    wire [3:0] boot_region_size = protection_word_shadow_q[3:0];
    wire empty_flag = maj3(protection_word_shadow_q[6:4]);
    wire boot_holds_loader = maj3(protection_word_shadow_q[9:7]);
    wire rd_open = maj3(protection_word_shadow_q[12:10]);
    wire wr_open = maj3(protection_word_shadow_q[15:13]);
    wire boot_def = boot_region_size != `FEP_NO_BOOT;
    // Code area start is the inverted size in 2K-byte units
    wire [16:0] code_start = {2'b00, ~boot_region_size, 11'h000};

    // Main block decode of the processor address
    wire blk0 = i_mem_addr[23:17] == 7'h00;
    wire blk1 = i_mem_addr[23:17] == 7'h01;
    wire blk2 = i_mem_addr[23:13] == `FEP_BLK2_TAG;
    wire any_blk = blk0 | blk1 | blk2;
    wire [3:0] sec = blk2 ? i_mem_addr[12:9] : i_mem_addr[16:13];
    wire [DW-1:0] wer = blk0 ? wer0_q : (blk1 ? wer1_q : wer2_q);
    wire sec_en = wer[sec];
    // Boot end is 2K aligned, so a page lies wholly in or out
    wire in_boot = blk0 & (i_mem_addr[16:0] < code_start);
    wire [AW-1:0] pg_addr = i_mem_addr & ~(blk2 ? `FEP_PG2_MASK : `FEP_PG01_MASK);

    wire per_ok = wr_open & any_blk & sec_en & ~in_boot;
    wire mer_ok = wr_open & any_blk & (&wer) & ~(blk0 & boot_def);
    wire word_ok = (i_mem_be == 2'b11) & ~i_mem_addr[0];
    wire prg_ok = wr_open & any_blk & sec_en & ~in_boot & word_ok;

    // Information block decode, bit 7 selects block 1
    wire ib1 = info_addr_reg_q[7];
    wire imer_ok = wr_open & (ib1 ? &wer1_q : ((&wer0_q) & ~boot_def));
    wire iprg_ok = wr_open & ib1 & wer1_q[15] & ~info_addr_reg_q[0];

    wire pe = ctrl_q[`FEP_C_PE];
    wire page_erase_cmd = ctrl_q[`FEP_C_PER];
    wire module_erase_cmd = ctrl_q[`FEP_C_MER];
    wire run = state_q[3] | state_q[4];
    wire busy = state_q[4];
    wire idata_wr = i_reg_wr & (i_reg_addr == `FEP_A_IDATA);
    wire mem_att = i_mem_wr & run & (pe | page_erase_cmd | module_erase_cmd);
    wire info_att = idata_wr & run & (pe | module_erase_cmd) & ~mem_att;

    // Candidate request; priority module, page erase, program
    reg [2:0] n_op;
    reg n_ok;
    reg n_info;
    reg [AW-1:0] n_addr;
    reg [DW-1:0] n_data;
    always @* begin
        n_op = 3'h0;
        n_ok = 1'b0;
        n_info = 1'b0;
        n_addr = i_mem_addr;
        n_data = i_mem_wdata;
        if (mem_att) begin
            if (module_erase_cmd) begin
                n_op = `FEP_OP_MERASE;
                n_ok = mer_ok;
            end else if (page_erase_cmd) begin
                n_op = `FEP_OP_PERASE;
                n_ok = per_ok;
                n_addr = pg_addr;
            end else begin
                n_op = `FEP_OP_PROG;
                n_ok = prg_ok;
            end
        end else if (info_att) begin
            n_info = 1'b1;
            n_addr = {16'h0000, info_addr_reg_q};
            n_data = i_reg_wdata;
            if (module_erase_cmd) begin
                n_op = `FEP_OP_MERASE;
                n_ok = imer_ok;
            end else begin
                n_op = `FEP_OP_PROG;
                n_ok = iprg_ok;
            end
        end
    end

    wire is_prog = n_op == `FEP_OP_PROG;
    wire is_erase = (n_op == `FEP_OP_MERASE) | (n_op == `FEP_OP_PERASE);
    wire op_prog = op_q == `FEP_OP_PROG;
    // Erase needs idle; one program may queue behind another
    wire prog_window = ~busy | (op_prog & (~pend_q | i_arr_done));
    wire erase_window = ~busy;
    wire take_prog = is_prog & n_ok & prog_window;
    wire take_erase = is_erase & n_ok & erase_window;
    wire fail_p = is_prog & ~n_ok & prog_window;
    wire fail_e = is_erase & ~n_ok & erase_window;

    wire launch_pend = busy & i_arr_done & pend_q;
    wire launch_new = (state_q[3] & (take_prog | take_erase))
        | (busy & i_arr_done & ~pend_q & take_prog);
    wire queue_new = busy & take_prog & ~(i_arr_done & ~pend_q);

    // Sequencer
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q <= S_LOAD;
            ld_idx_q <= 1'b0;
            function_word_shadow_q <= 16'h0000;
            protection_word_shadow_q <= 16'hFFFF;
            op_q <= 3'h0;
            pend_q <= 1'b0;
            pend_addr_q <= 24'h00_0000;
            pend_data_q <= 16'h0000;
            pend_info_q <= 1'b0;
            start_q <= 1'b0;
            info_q <= 1'b0;
            addr_q <= 24'h00_0000;
            wdata_q <= 16'h0000;
            rd_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            rd_q <= 1'b0;
            case (state_q)
                S_LOAD: begin
                    rd_q <= 1'b1;
                    info_q <= 1'b1;
                    addr_q <= ld_idx_q ? `FEP_PW_ADDR : `FEP_FW_ADDR;
                    state_q <= S_LWAIT;
                end
                S_LWAIT: begin
                    if (i_arr_rvalid) begin
                        if (ld_idx_q) begin
                            protection_word_shadow_q <= i_arr_rdata;
                            state_q <= S_DEC;
                        end else begin
                            function_word_shadow_q <= i_arr_rdata;
                            ld_idx_q <= 1'b1;
                            state_q <= S_LOAD;
                        end
                    end
                end
                S_DEC: begin
                    state_q <= S_IDLE;
                end
                S_IDLE: begin
                    if (launch_new) begin
                        state_q <= S_OP;
                    end
                end
                S_OP: begin
                    if (i_arr_done & ~launch_pend & ~launch_new) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_LOAD;
                end
            endcase
            if (launch_pend) begin
                start_q <= 1'b1;
                op_q <= `FEP_OP_PROG;
                info_q <= pend_info_q;
                addr_q <= pend_addr_q;
                wdata_q <= pend_data_q;
            end else if (launch_new) begin
                start_q <= 1'b1;
                op_q <= n_op;
                info_q <= n_info;
                addr_q <= n_addr;
                wdata_q <= n_data;
            end
            if (queue_new) begin
                pend_q <= 1'b1;
                pend_info_q <= n_info;
                pend_addr_q <= n_addr;
                pend_data_q <= n_data;
            end else if (launch_pend) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Registers; a fail event beats a same-cycle clear
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl_q <= 3'h0;
            erase_fail_flag_q <= 1'b0;
            program_fail_flag_q <= 1'b0;
            info_addr_reg_q <= 8'h00;
            info_data_reg_q <= 16'h0000;
            wer0_q <= `FEP_WER_RST;
            wer1_q <= `FEP_WER_RST;
            wer2_q <= `FEP_WER_RST;
        end else begin
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `FEP_A_CTRL: ctrl_q <= i_reg_wdata[2:0];
                    `FEP_A_IADDR: info_addr_reg_q <= i_reg_wdata[7:0];
                    `FEP_A_IDATA: info_data_reg_q <= i_reg_wdata;
                    `FEP_A_WER0: wer0_q <= i_reg_wdata;
                    `FEP_A_WER1: wer1_q <= i_reg_wdata;
                    `FEP_A_WER2: wer2_q <= i_reg_wdata;
                    default: ctrl_q <= ctrl_q;
                endcase
            end
            if (fail_e) begin
                erase_fail_flag_q <= 1'b1;
            end else if (i_reg_wr & (i_reg_addr == `FEP_A_STAT)
                    & i_reg_wdata[`FEP_S_ERASE_FAIL_FLAG]) begin
                erase_fail_flag_q <= 1'b0;
            end
            if (fail_p) begin
                program_fail_flag_q <= 1'b1;
            end else if (i_reg_wr & (i_reg_addr == `FEP_A_STAT)
                    & i_reg_wdata[`FEP_S_PROGRAM_FAIL_FLAG]) begin
                program_fail_flag_q <= 1'b0;
            end
        end
    end

    // Straps are async pins: two flops before decode
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            s0_m_q <= 1'b0;
            s0_q <= 1'b0;
            s1_m_q <= 1'b0;
            s1_q <= 1'b0;
        end else begin
            s0_m_q <= i_strap_pin_0;
            s0_q <= s0_m_q;
            s1_m_q <= i_strap_pin_1;
            s1_q <= s1_m_q;
        end
    end

    // Start-up decode from the shadowed protection word
    reg [3:0] m_d;
    reg [AW-1:0] a_d;
    reg h_d;
    always @* begin
        m_d = `FEP_M_INT;
        a_d = 24'h00_0000;
        h_d = 1'b0;
        if (~s1_q & ~s0_q) begin
            m_d = `FEP_M_DBG;
        end else if (s1_q & (~s0_q | empty_flag)) begin
            m_d = `FEP_M_ISP;
            a_d = {7'h00, code_start};
            h_d = ~boot_def | (s0_q & ~boot_holds_loader);
        end else if (~empty_flag) begin
            m_d = s1_q ? `FEP_M_INT : `FEP_M_EXT;
            a_d = boot_holds_loader ? {7'h00, code_start} : 24'h00_0000;
        end else begin
            m_d = `FEP_M_EXT;
            h_d = 1'b1;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            done_q <= 1'b0;
            mode_q <= `FEP_M_INT;
            saddr_q <= 24'h00_0000;
            hold_q <= 1'b1;
            rdata_q <= 16'h0000;
        end else begin
            if (state_q[2]) begin
                done_q <= 1'b1;
                mode_q <= m_d;
                saddr_q <= a_d;
                hold_q <= h_d;
            end
            rdata_q <= 16'h0000;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `FEP_A_CTRL: rdata_q <= {13'h0000, ctrl_q};
                    `FEP_A_STAT: rdata_q <= {12'h000, program_fail_flag_q, erase_fail_flag_q, pend_q, busy};
                    `FEP_A_IADDR: rdata_q <= {8'h00, info_addr_reg_q};
                    `FEP_A_IDATA: rdata_q <= info_data_reg_q;
                    `FEP_A_WER0: rdata_q <= wer0_q;
                    `FEP_A_WER1: rdata_q <= wer1_q;
                    `FEP_A_WER2: rdata_q <= wer2_q;
                    `FEP_A_FWS: rdata_q <= function_word_shadow_q;
                    `FEP_A_PWS: rdata_q <= protection_word_shadow_q;
                    `FEP_A_MODE: rdata_q <= {10'h000, hold_q, mode_q, done_q};
                    default: rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_arr_start = start_q;
    assign o_arr_op = op_q;
    assign o_arr_info = info_q;
    assign o_arr_addr = addr_q;
    assign o_arr_wdata = wdata_q;
    assign o_arr_rd = rd_q;
    assign o_boot_done = done_q;
    assign o_start_mode = mode_q;
    assign o_start_addr = saddr_q;
    assign o_hold_reset = hold_q;
    // Guards closed until the protection word is loaded
    assign o_prog_write_allow = done_q & wr_open;
    assign o_ext_read_allow = done_q & rd_open;
    assign o_dbg_read_allow = done_q & rd_open & wr_open;
    assign o_flash_busy_flag = busy;

endmodule

// File: verification/fepseq_core_chk.sv
// Port checks on the sequencer core.
// Bound into the core; sees only its ports.
`timescale 1ns/1ps
`include "fepseq_defines.vh"

module fepseq_core_chk #(
    parameter AW = 24,
    parameter DW = 16
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Array side
    input wire i_arr_done,
    input wire o_arr_start,
    input wire [2:0] o_arr_op,
    input wire o_arr_info,
    input wire [AW-1:0] o_arr_addr,
    input wire o_arr_rd,
    input wire o_flash_busy_flag,
    // Start-up decode and guards
    input wire o_boot_done,
    input wire [3:0] o_start_mode,
    input wire [AW-1:0] o_start_addr,
    input wire o_hold_reset,
    input wire o_prog_write_allow,
    input wire o_ext_read_allow,
    input wire o_dbg_read_allow
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    property p_first_read;
        $fell(i_rst) |-> ##[0:2] (o_arr_rd && o_arr_info && o_arr_addr == 24'h00_007E);
    endproperty
    a_first_read: assert property (p_first_read) else $error("no function read");

    property p_start_busy;
        o_arr_start |-> o_flash_busy_flag && $onehot(o_arr_op);
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start without busy");

    property p_busy_end;
        $fell(o_flash_busy_flag) |-> $past(i_arr_done);
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy ended early");

    property p_page_align;
        o_arr_start && o_arr_op == `FEP_OP_PERASE |-> !o_arr_info &&
            ((o_arr_addr < 24'h04_0000) ? o_arr_addr[9:0] == 10'h000 : o_arr_addr[8:0] == 9'h000);
    endproperty
    a_page_align: assert property (p_page_align) else $error("page address");

    property p_word_align;
        o_arr_start && o_arr_op == `FEP_OP_PROG |-> o_arr_addr[0] == 1'b0;
    endproperty
    a_word_align: assert property (p_word_align) else $error("odd address");

    property p_info0_prog;
        o_arr_start && o_arr_op == `FEP_OP_PROG && o_arr_info |-> o_arr_addr[7];
    endproperty
    a_info0_prog: assert property (p_info0_prog) else $error("info 0 programmed");

    property p_write_guard;
        o_arr_start |-> o_prog_write_allow;
    endproperty
    a_write_guard: assert property (p_write_guard) else $error("guard closed");

    property p_dbg_read;
        o_boot_done |-> o_dbg_read_allow == (o_ext_read_allow && o_prog_write_allow);
    endproperty
    a_dbg_read: assert property (p_dbg_read) else $error("debug read guard");

    property p_hold_pre;
        !o_boot_done |-> o_hold_reset && !o_prog_write_allow && !o_ext_read_allow;
    endproperty
    a_hold_pre: assert property (p_hold_pre) else $error("early release");

    property p_debug_start;
        o_boot_done && o_start_mode == `FEP_M_DBG |-> o_start_addr == 24'h00_0000 && !o_hold_reset;
    endproperty
    a_debug_start: assert property (p_debug_start) else $error("debug start");

    property p_code_start;
        o_boot_done |-> o_start_addr[10:0] == 11'h000 && o_start_addr <= 24'h00_7800;
    endproperty
    a_code_start: assert property (p_code_start) else $error("start range");
endmodule

bind fepseq_core fepseq_core_chk #(.AW(AW), .DW(DW)) fepseq_core_chk_inst (.*);

// File: verification/fepseq_flash_model.sv
// Flash array model: ends each operation, answers word reads.
// Assumes one operation at a time; i_slow stretches both answers.
`timescale 1ns/1ps

module fepseq_flash_model (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Requests
    input wire i_arr_start,
    input wire i_arr_rd,
    input wire [23:0] i_arr_addr,
    // Stored words and pace
    input wire [15:0] i_func_word,
    input wire [15:0] i_prot_word,
    input wire i_slow,
    // Answers
    output logic o_arr_done,
    output logic o_arr_rvalid,
    output wire [15:0] o_arr_rdata
);
    logic [5:0] op_cnt_q;
    logic [2:0] rd_cnt_q;
    logic rd_pend_q;
    logic [15:0] word_q;

    // Inverse off the valid cycle, so a stale word never passes
    assign o_arr_rdata = o_arr_rvalid ? word_q : ~word_q;

    always @(posedge i_clk_sys) begin
        o_arr_done <= 1'b0;
        o_arr_rvalid <= 1'b0;
        if (i_rst) begin
            op_cnt_q <= 6'h00;
            rd_cnt_q <= 3'h0;
            rd_pend_q <= 1'b0;
            word_q <= 16'h0000;
        end else begin
            if (i_arr_start) begin
                op_cnt_q <= i_slow ? 6'h1E : 6'h03;
            end else if (op_cnt_q != 6'h00) begin
                op_cnt_q <= op_cnt_q - 6'h01;
                o_arr_done <= (op_cnt_q == 6'h01);
            end
            if (i_arr_rd) begin
                rd_pend_q <= 1'b1;
                rd_cnt_q <= i_slow ? 3'h5 : 3'h0;
                word_q <= (i_arr_addr[7:0] == 8'h7E) ? i_func_word : i_prot_word;
            end else if (rd_pend_q) begin
                if (rd_cnt_q == 3'h0) begin
                    o_arr_rvalid <= 1'b1;
                    rd_pend_q <= 1'b0;
                end else begin
                    rd_cnt_q <= rd_cnt_q - 3'h1;
                end
            end
        end
    end
endmodule

// File: verification/flash_erase_program_sequencer_tb.sv
// Self-checking bench for the sequencer core.
// Uses the flash model and the bound checker.
`timescale 1ns/1ps
`include "fepseq_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module flash_erase_program_sequencer_tb;
    logic i_clk_sys = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_mem_wr = 1'b0;
    logic i_strap_pin_0 = 1'b1, i_strap_pin_1 = 1'b1, i_slow = 1'b0;
    logic [3:0] i_reg_addr = 4'h0;
    logic [15:0] i_reg_wdata = 16'h0000, i_mem_wdata = 16'h0000, prot_word = 16'hFF8D;
    logic [23:0] i_mem_addr = 24'h00_0000;
    logic [1:0] i_mem_be = 2'b11;
    wire [15:0] o_reg_rdata, o_arr_wdata, i_arr_rdata;
    wire [23:0] o_arr_addr, o_start_addr;
    wire [2:0] o_arr_op;
    wire [3:0] o_start_mode;
    wire o_arr_start, o_arr_info, o_arr_rd, i_arr_done, i_arr_rvalid, o_boot_done, o_hold_reset;
    wire o_prog_write_allow, o_ext_read_allow, o_dbg_read_allow, o_flash_busy_flag;
    int bad_count = 0, check_count = 0, start_count = 0, start_seen = 0;
    localparam [15:0] FUNC = 16'hA5C3;

    fepseq_core fepseq_core_inst (.*);

    fepseq_flash_model fepseq_flash_model_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_arr_start(o_arr_start), .i_arr_rd(o_arr_rd), .i_arr_addr(o_arr_addr),
        .i_func_word(FUNC), .i_prot_word(prot_word), .i_slow(i_slow),
        .o_arr_done(i_arr_done), .o_arr_rvalid(i_arr_rvalid), .o_arr_rdata(i_arr_rdata));

    always #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (o_arr_start === 1'b1) start_count++;

    task automatic final_report;
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // 0 boot done, 1 new start, 2 idle
    task automatic wait_for(input int which);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge i_clk_sys);
            #1;
            if ((which == 0 && o_boot_done === 1'b1) || (which == 1 && start_count != start_seen)
                || (which == 2 && o_flash_busy_flag === 1'b0)) break;
        end
        if (i == 400) begin
            bad_count++;
            final_report;
        end
    endtask

    task automatic wr(input [3:0] a, input [15:0] d);
        start_seen = start_count;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask

    task automatic rd(input [3:0] a, input [15:0] e);
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1;
        `CHK(o_reg_rdata, e)
    endtask

    // Data follows the address, so the word is predictable
    task automatic mw(input [23:0] a, input [1:0] be);
        start_seen = start_count;
        @(posedge i_clk_sys);
        i_mem_wr <= 1'b1;
        i_mem_addr <= a;
        i_mem_be <= be;
        i_mem_wdata <= a[15:0] ^ 16'h5A5A;
        @(posedge i_clk_sys);
        i_mem_wr <= 1'b0;
    endtask

    task automatic expect_start(input [2:0] op, input info, input [23:0] addr);
        wait_for(1);
        `CHK(o_arr_op, op)
        `CHK(o_arr_info, info)
        `CHK(o_arr_addr, addr)
        start_seen = start_count;
    endtask

    // Refused: fail flag set, nothing started, then cleared
    task automatic refuse(input [15:0] st);
        rd(`FEP_A_STAT, st);
        `CHK(start_count, start_seen)
        wr(`FEP_A_STAT, 16'h000C);
        rd(`FEP_A_STAT, 16'h0000);
    endtask

    task automatic do_boot(input [15:0] prot, input [1:0] st, input [3:0] mode,
                           input [23:0] addr, input hold);
        prot_word = prot;
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        {i_strap_pin_1, i_strap_pin_0} <= st;
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        wait_for(0);
        `CHK(o_hold_reset, hold)
        if (!hold) begin
            `CHK(o_start_mode, mode)
            `CHK(o_start_addr, addr)
        end
        rd(`FEP_A_PWS, prot);
        rd(`FEP_A_FWS, FUNC);
    endtask

    task automatic scen_startup;
        do_boot(16'hFF8D, 2'b11, `FEP_M_INT, 24'h00_1000, 1'b0);
        do_boot(16'hFC0D, 2'b11, `FEP_M_INT, 24'h00_0000, 1'b0);
        do_boot(16'hFFF0, 2'b11, `FEP_M_ISP, 24'h00_7800, 1'b0);
        do_boot(16'hFFFF, 2'b11, `FEP_M_ISP, 24'h00_0000, 1'b1);
        do_boot(16'hFFEE, 2'b11, `FEP_M_ISP, 24'h00_0800, 1'b0);
        do_boot(16'hFF9E, 2'b11, `FEP_M_INT, 24'h00_0800, 1'b0);
        do_boot(16'hFF8D, 2'b10, `FEP_M_ISP, 24'h00_1000, 1'b0);
        do_boot(16'hFFF0, 2'b00, `FEP_M_DBG, 24'h00_0000, 1'b0);
        wr(`FEP_A_FWS, 16'h0000);
        rd(`FEP_A_FWS, FUNC);
        rd(4'hF, 16'h0000);
    endtask

    task automatic scen_guards;
        do_boot(16'h700F, 2'b11, `FEP_M_INT, 24'h00_0000, 1'b0);
        `CHK({o_prog_write_allow, o_ext_read_allow, o_dbg_read_allow}, 3'b100)
        do_boot(16'h9C0F, 2'b11, `FEP_M_INT, 24'h00_0000, 1'b0);
        `CHK({o_prog_write_allow, o_ext_read_allow, o_dbg_read_allow}, 3'b010)
        wr(`FEP_A_WER0, 16'h0010);
        wr(`FEP_A_CTRL, 16'h0001);
        mw(24'h00_8000, 2'b11);
        refuse(16'h0008);
    endtask

    task automatic scen_program;
        do_boot(16'hFF8D, 2'b11, `FEP_M_INT, 24'h00_1000, 1'b0);
        i_slow <= 1'b1;
        wr(`FEP_A_WER0, 16'h0011);
        wr(`FEP_A_CTRL, 16'h0001);
        mw(24'h00_8000, 2'b11);
        expect_start(`FEP_OP_PROG, 1'b0, 24'h00_8000);
        `CHK(o_arr_wdata, 16'hDA5A)
        mw(24'h00_8002, 2'b11);
        rd(`FEP_A_STAT, 16'h0003);
        expect_start(`FEP_OP_PROG, 1'b0, 24'h00_8002);
        rd(`FEP_A_STAT, 16'h0001);
        wait_for(2);
        rd(`FEP_A_STAT, 16'h0000);
    endtask

    task automatic scen_refuse;
        mw(24'h00_8001, 2'b11);
        refuse(16'h0008);
        mw(24'h00_8004, 2'b01);
        refuse(16'h0008);
        mw(24'h00_0100, 2'b11);
        refuse(16'h0008);
        mw(24'h00_A000, 2'b11);
        refuse(16'h0008);
        wr(`FEP_A_IADDR, 16'h0010);
        wr(`FEP_A_IDATA, 16'h1234);
        refuse(16'h0008);
        wr(`FEP_A_WER1, 16'h8000);
        wr(`FEP_A_IADDR, 16'h00FE);
        wr(`FEP_A_IDATA, 16'hBEEF);
        expect_start(`FEP_OP_PROG, 1'b1, 24'h00_00FE);
        `CHK(o_arr_wdata, 16'hBEEF)
        wait_for(2);
    endtask

    task automatic scen_erase;
        wr(`FEP_A_CTRL, 16'h0002);
        mw(24'h00_8123, 2'b11);
        expect_start(`FEP_OP_PERASE, 1'b0, 24'h00_8000);
        rd(`FEP_A_STAT, 16'h0001);
        wait_for(2);
        wr(`FEP_A_WER2, 16'h0002);
        mw(24'h0D_0345, 2'b11);
        expect_start(`FEP_OP_PERASE, 1'b0, 24'h0D_0200);
        wait_for(2);
        mw(24'h00_0400, 2'b11);
        refuse(16'h0004);
        mw(24'h00_4400, 2'b11);
        refuse(16'h0004);
        wr(`FEP_A_CTRL, 16'h0004);
        wr(`FEP_A_WER0, 16'hFFFF);
        mw(24'h00_9000, 2'b11);
        refuse(16'h0004);
        wr(`FEP_A_WER1, 16'h7FFF);
        mw(24'h02_1234, 2'b11);
        refuse(16'h0004);
        wr(`FEP_A_WER1, 16'hFFFF);
        mw(24'h02_1234, 2'b11);
        wait_for(1);
        `CHK({o_arr_op, o_arr_info}, {`FEP_OP_MERASE, 1'b0})
        wait_for(2);
        wr(`FEP_A_IADDR, 16'h0090);
        wr(`FEP_A_IDATA, 16'h0000);
        expect_start(`FEP_OP_MERASE, 1'b1, 24'h00_0090);
        wait_for(2);
        wr(`FEP_A_IADDR, 16'h0010);
        wr(`FEP_A_IDATA, 16'h0000);
        refuse(16'h0004);
    endtask

    initial begin
        scen_startup;
        scen_guards;
        scen_program;
        scen_refuse;
        scen_erase;
        final_report;
    end
endmodule
